// ---- inc/ttc_pkg.sv ----
// Purpose: Shared constants and types of the thermostat three-wire control block.
// Assumes: System clock of 125 MHz; temperatures are 9-bit two's complement, half-degree LSB.
// Notes: Command codes, configuration field positions, reset values and timing counts.
package ttc_pkg;

  // Serial command codes, shifted in least significant bit first.
  localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
  localparam logic [7:0] CMD_WRITE_UPPER = 8'h01;
  localparam logic [7:0] CMD_WRITE_LOWER = 8'h02;
  localparam logic [7:0] CMD_READ_UPPER = 8'hA1;
  localparam logic [7:0] CMD_READ_LOWER = 8'hA2;
  localparam logic [7:0] CMD_BEGIN_CONV = 8'hEE;
  localparam logic [7:0] CMD_HALT_CONV = 8'h22;
  localparam logic [7:0] CMD_WRITE_CFG = 8'h0C;
  localparam logic [7:0] CMD_READ_CFG = 8'hAC;

  // Lengths of the serial fields in clock cycles.
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h09;
  localparam logic [4:0] CFG_BITS = 5'h08;

  // Bit positions inside the configuration/status byte.
  localparam int CFG_DONE_BIT = 7;
  localparam int CFG_UPPER_SEEN_BIT = 6;
  localparam int CFG_LOWER_SEEN_BIT = 5;
  localparam int CFG_HOST_BIT = 1;
  localparam int CFG_SINGLE_BIT = 0;

  // Reset values of the stored settings.
  localparam logic [8:0] UPPER_LIMIT_RST = 9'h000;
  localparam logic [8:0] LOWER_LIMIT_RST = 9'h000;
  localparam logic [8:0] TEMP_RESULT_RST = 9'h000;
  localparam logic HOST_ATTACHED_RST = 1'b1;
  localparam logic SINGLE_CONV_RST = 1'b0;

  // Timing: times in milliseconds, counts in system clock cycles.
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned CONV_TIME_MS = 1000;
  localparam int unsigned CONV_CYCLES_DFLT = CONV_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned HOLD_TIME_MS = 10;
  localparam int unsigned HOLD_CYCLES_DFLT = HOLD_TIME_MS * CLK_FREQ_KHZ;

  typedef logic signed [8:0] ttc_temp_t;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic dq;
  } ttc_pins_t;

  typedef struct packed {
    logic upper_seen;
    logic lower_seen;
    logic host_attached;
    logic single_conv;
  } ttc_cfg_t;

  typedef enum logic [1:0] {
    XFER_CMD = 2'b00,
    XFER_WRITE = 2'b01,
    XFER_READ = 2'b10,
    XFER_DONE = 2'b11
  } ttc_xfer_t;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } ttc_conv_t;

endpackage

// ---- hw/ttc_pin_sync.sv ----
// Purpose: Two-stage synchroniser for the three serial port pins.
// Assumes: Pins are asynchronous to sys_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
module ttc_pin_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire ttc_pkg::ttc_pins_t raw,
  output ttc_pkg::ttc_pins_t synced
);

  ttc_pkg::ttc_pins_t stage1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= raw;
      synced <= stage1;
    end
  end

endmodule

// ---- hw/ttc_thermostat.sv ----
// Purpose: Thermostat control with three-wire serial port and standalone convert pin.
// Assumes: sensor_temp is a 9-bit reading from measurement logic on sys_clk.
`timescale 1ns/10ps
module ttc_thermostat #(
  parameter int unsigned CONV_CYCLES = ttc_pkg::CONV_CYCLES_DFLT,
  parameter int unsigned HOLD_CYCLES = ttc_pkg::HOLD_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic transfer_select,
  input wire logic clock_or_convert_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire ttc_pkg::ttc_temp_t sensor_temp,
  output logic conversion_active,
  output logic over_limit_out,
  output logic under_limit_out,
  output logic hysteresis_out
);

  ttc_pkg::ttc_pins_t pins_raw;
  ttc_pkg::ttc_pins_t pins_s;

  assign pins_raw = '{sel: transfer_select, sclk: clock_or_convert_pin, dq: serial_data_in};

  ttc_pin_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .raw(pins_raw),
    .synced(pins_s)
  );

  // Reset values in the signed temperature type, declared ahead of their use.
  localparam ttc_pkg::ttc_temp_t UPPER_LIMIT_RST_S = ttc_pkg::UPPER_LIMIT_RST;
  localparam ttc_pkg::ttc_temp_t LOWER_LIMIT_RST_S = ttc_pkg::LOWER_LIMIT_RST;
  localparam ttc_pkg::ttc_temp_t TEMP_RESULT_RST_S = ttc_pkg::TEMP_RESULT_RST;

  // Stored state.
  ttc_pkg::ttc_cfg_t cfg;
  ttc_pkg::ttc_temp_t upper_limit;
  ttc_pkg::ttc_temp_t lower_limit;
  ttc_pkg::ttc_temp_t temp_result;
  ttc_pkg::ttc_xfer_t xfer;
  ttc_pkg::ttc_conv_t conv_state;
  logic sclk_prev;
  logic [4:0] bit_cnt;
  logic [4:0] data_len;
  logic [7:0] cmd_reg;
  logic [8:0] rx;
  logic [8:0] tx;
  logic cont_run;
  logic [31:0] conv_cnt;
  logic [31:0] low_cnt;

  // Edge detection on the synchronised clock pin.
  wire sel = pins_s.sel;
  wire sclk = pins_s.sclk;
  wire sclk_rise = sel & sclk & ~sclk_prev;
  wire sclk_fall = sel & ~sclk & sclk_prev;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclk_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk;
    end
  end

  // Serial receive path: each bit enters at the top, so the first bit ends lowest.
  wire [8:0] shifted_rx = {pins_s.dq, rx[8:1]};
  wire [4:0] bits_after = bit_cnt + 5'h01;
  wire [7:0] cmd_code = shifted_rx[8:1];
  wire cmd_done = (xfer == ttc_pkg::XFER_CMD) && sclk_rise && (bits_after == ttc_pkg::CMD_BITS);
  wire write_done = (xfer == ttc_pkg::XFER_WRITE) && sclk_rise && (bits_after == data_len);

  // Command decode.
  wire code_wr_upper = (cmd_code == ttc_pkg::CMD_WRITE_UPPER);
  wire code_wr_lower = (cmd_code == ttc_pkg::CMD_WRITE_LOWER);
  wire code_wr_cfg = (cmd_code == ttc_pkg::CMD_WRITE_CFG);
  wire code_rd_temp = (cmd_code == ttc_pkg::CMD_READ_TEMP);
  wire code_rd_upper = (cmd_code == ttc_pkg::CMD_READ_UPPER);
  wire code_rd_lower = (cmd_code == ttc_pkg::CMD_READ_LOWER);
  wire code_rd_cfg = (cmd_code == ttc_pkg::CMD_READ_CFG);
  wire code_is_write = code_wr_upper | code_wr_lower | code_wr_cfg;
  wire code_is_read = code_rd_temp | code_rd_upper | code_rd_lower | code_rd_cfg;
  wire begin_cmd = cmd_done & (cmd_code == ttc_pkg::CMD_BEGIN_CONV);
  wire halt_cmd = cmd_done & (cmd_code == ttc_pkg::CMD_HALT_CONV);

  // Status byte as seen by the host.
  logic [7:0] cfg_byte;

  always_comb begin
    cfg_byte = 8'h00;
    cfg_byte[ttc_pkg::CFG_DONE_BIT] = (conv_state == ttc_pkg::CONV_IDLE);
    cfg_byte[ttc_pkg::CFG_UPPER_SEEN_BIT] = cfg.upper_seen;
    cfg_byte[ttc_pkg::CFG_LOWER_SEEN_BIT] = cfg.lower_seen;
    cfg_byte[ttc_pkg::CFG_HOST_BIT] = cfg.host_attached;
    cfg_byte[ttc_pkg::CFG_SINGLE_BIT] = cfg.single_conv;
  end

  // Word loaded into the transmit register when a read command completes.
  wire [8:0] read_word = code_rd_temp ? temp_result :
                         code_rd_upper ? upper_limit :
                         code_rd_lower ? lower_limit :
                         {1'b0, cfg_byte};

  // Value collected by a write: a 9-bit limit or an 8-bit configuration byte.
  wire [8:0] write_word = (data_len == ttc_pkg::WORD_BITS) ? shifted_rx : {1'b0, shifted_rx[8:1]};
  wire wr_upper = write_done & (cmd_reg == ttc_pkg::CMD_WRITE_UPPER);
  wire wr_lower = write_done & (cmd_reg == ttc_pkg::CMD_WRITE_LOWER);
  wire wr_cfg = write_done & (cmd_reg == ttc_pkg::CMD_WRITE_CFG);

  // Transfer sequencer. Select low aborts the transfer in progress and floats the line.
  always_ff @(posedge sys_clk) begin
    if (reset || !sel) begin
      xfer <= ttc_pkg::XFER_CMD;
      bit_cnt <= 5'h00;
      data_len <= ttc_pkg::WORD_BITS;
      cmd_reg <= 8'h00;
      rx <= 9'h000;
      tx <= 9'h000;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      unique case (xfer)
        ttc_pkg::XFER_CMD: begin
          if (sclk_rise) begin
            rx <= shifted_rx;
            bit_cnt <= bits_after;
          end
          if (cmd_done) begin
            bit_cnt <= 5'h00;
            cmd_reg <= cmd_code;
            tx <= read_word;
            data_len <= code_wr_cfg ? ttc_pkg::CFG_BITS : ttc_pkg::WORD_BITS;
            if (code_is_write) begin
              xfer <= ttc_pkg::XFER_WRITE;
            end else if (code_is_read) begin
              xfer <= ttc_pkg::XFER_READ;
            end else begin
              xfer <= ttc_pkg::XFER_DONE;
            end
          end
        end
        ttc_pkg::XFER_WRITE: begin
          if (sclk_rise) begin
            rx <= shifted_rx;
            bit_cnt <= bits_after;
          end
          if (write_done) begin
            xfer <= ttc_pkg::XFER_DONE;
          end
        end
        ttc_pkg::XFER_READ: begin
          if (sclk_fall) begin
            serial_data_out <= tx[0];
            tx <= {1'b0, tx[8:1]};
            serial_data_oe <= 1'b1;
          end else if (sclk_rise) begin
            serial_data_oe <= 1'b0;
          end
        end
        ttc_pkg::XFER_DONE: begin
          serial_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // Limit registers, 9-bit two's complement.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      upper_limit <= UPPER_LIMIT_RST_S;
      lower_limit <= LOWER_LIMIT_RST_S;
    end else begin
      if (wr_upper) begin
        upper_limit <= ttc_pkg::ttc_temp_t'(write_word);
      end
      if (wr_lower) begin
        lower_limit <= ttc_pkg::ttc_temp_t'(write_word);
      end
    end
  end

  // Standalone conversion pin: active only with no host and select low.
  wire standalone = ~cfg.host_attached & ~sel;
  wire pin_fall = standalone & sclk_prev & ~sclk;
  wire held_long = standalone & ~sclk & (low_cnt >= HOLD_CYCLES);

  always_ff @(posedge sys_clk) begin
    if (reset || !standalone || sclk) begin
      low_cnt <= 32'h00000000;
    end else if (low_cnt < HOLD_CYCLES) begin
      low_cnt <= low_cnt + 32'h00000001;
    end
  end

  // Continuous run request from the serial commands.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cont_run <= 1'b0;
    end else if (halt_cmd) begin
      cont_run <= 1'b0;
    end else if (begin_cmd) begin
      cont_run <= ~cfg.single_conv;
    end
  end

  // Conversion timer.
  wire start_req = begin_cmd | pin_fall;
  wire conv_end = (conv_state == ttc_pkg::CONV_BUSY) && (conv_cnt == CONV_CYCLES - 32'h00000001);
  wire conv_again = (cont_run & ~halt_cmd) | held_long;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      conv_state <= ttc_pkg::CONV_IDLE;
      conv_cnt <= 32'h00000000;
    end else begin
      unique case (conv_state)
        ttc_pkg::CONV_IDLE: begin
          conv_cnt <= 32'h00000000;
          if (start_req || held_long) begin
            conv_state <= ttc_pkg::CONV_BUSY;
          end
        end
        ttc_pkg::CONV_BUSY: begin
          if (conv_end) begin
            conv_cnt <= 32'h00000000;
            if (!conv_again) begin
              conv_state <= ttc_pkg::CONV_IDLE;
            end
          end else begin
            conv_cnt <= conv_cnt + 32'h00000001;
          end
        end
      endcase
    end
  end

  assign conversion_active = (conv_state == ttc_pkg::CONV_BUSY);

  // Comparisons against the limits, applied only at conversion completion.
  wire at_or_above = (sensor_temp >= upper_limit);
  wire at_or_below = (sensor_temp <= lower_limit);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      temp_result <= TEMP_RESULT_RST_S;
      over_limit_out <= 1'b0;
      under_limit_out <= 1'b0;
      hysteresis_out <= 1'b0;
    end else if (conv_end) begin
      temp_result <= sensor_temp;
      over_limit_out <= at_or_above;
      under_limit_out <= at_or_below;
      if (at_or_above) begin
        hysteresis_out <= 1'b1;
      end else if (at_or_below) begin
        hysteresis_out <= 1'b0;
      end
    end
  end

  // Configuration register. A flag event in the same cycle as a clearing write wins.
  wire set_upper = conv_end & at_or_above;
  wire set_lower = conv_end & at_or_below;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg.upper_seen <= 1'b0;
      cfg.lower_seen <= 1'b0;
      cfg.host_attached <= ttc_pkg::HOST_ATTACHED_RST;
      cfg.single_conv <= ttc_pkg::SINGLE_CONV_RST;
    end else begin
      if (set_upper) begin
        cfg.upper_seen <= 1'b1;
      end else if (wr_cfg) begin
        cfg.upper_seen <= write_word[ttc_pkg::CFG_UPPER_SEEN_BIT];
      end
      if (set_lower) begin
        cfg.lower_seen <= 1'b1;
      end else if (wr_cfg) begin
        cfg.lower_seen <= write_word[ttc_pkg::CFG_LOWER_SEEN_BIT];
      end
      if (wr_cfg) begin
        cfg.host_attached <= write_word[ttc_pkg::CFG_HOST_BIT];
        cfg.single_conv <= write_word[ttc_pkg::CFG_SINGLE_BIT];
      end
    end
  end

endmodule

// ---- dv/ttc_thermostat_chk.sv ----
// Purpose: Port-level assertions for the thermostat three-wire control block.
// Assumes: Pins reach sys_clk through a short synchroniser; pin levels stand >= 4 cycles.
// Notes: Attached by bind to every instance of the top module.
`timescale 1ns/10ps
module ttc_thermostat_chk #(
  parameter int unsigned CONV_CYCLES = 50,
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic transfer_select,
  input wire logic clock_or_convert_pin,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic conversion_active,
  input wire logic over_limit_out,
  input wire logic under_limit_out,
  input wire logic hysteresis_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [31:0] conv_cnt;
  always_ff @(posedge sys_clk) begin
    if (reset || !conversion_active) conv_cnt <= 32'h00000000;
    else if (conv_cnt == CONV_CYCLES) conv_cnt <= 32'h00000001;
    else conv_cnt <= conv_cnt + 32'h00000001;
  end
  a_oe_clk_high: assert property (clock_or_convert_pin [*4] |-> !serial_data_oe)
    else $error("data line driven while serial clock high");
  a_oe_no_select: assert property (!transfer_select [*4] |-> !serial_data_oe)
    else $error("data line driven without select");
  a_oe_after_fall: assert property ($rose(serial_data_oe) |-> !clock_or_convert_pin)
    else $error("data drive began outside the clock low phase");
  a_oe_in_frame: assert property ($rose(serial_data_oe) |-> transfer_select)
    else $error("data drive began outside a frame");
  a_bit_steady: assert property (serial_data_oe && $past(serial_data_oe) |->
    $stable(serial_data_out))
    else $error("output bit changed while driven");
  a_conv_length: assert property ($fell(conversion_active) |->
    conv_cnt == CONV_CYCLES)
    else $error("conversion length wrong");
  a_conv_bound: assert property (!$stable({over_limit_out, under_limit_out, hysteresis_out})
    |-> conv_cnt == CONV_CYCLES)
    else $error("thermostat output changed off the conversion end");
  a_outs_at_end: assert property (!$stable({over_limit_out, under_limit_out, hysteresis_out})
    |-> $past(conversion_active) || $past(conversion_active, 2))
    else $error("thermostat output changed outside a conversion end");
  a_hyst_over: assert property (over_limit_out |-> hysteresis_out)
    else $error("hysteresis output low while over limit");
  a_hyst_clear: assert property ($fell(hysteresis_out) |-> under_limit_out)
    else $error("hysteresis output cleared above lower limit");
  c_read: cover property ($rose(serial_data_oe));
  c_conv: cover property ($fell(conversion_active));
  c_hyst: cover property ($fell(hysteresis_out));
endmodule

bind ttc_thermostat ttc_thermostat_chk #(.CONV_CYCLES(CONV_CYCLES), .HOLD_CYCLES(HOLD_CYCLES))
  chk_i (.sys_clk(sys_clk), .reset(reset), .transfer_select(transfer_select),
  .clock_or_convert_pin(clock_or_convert_pin), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe), .conversion_active(conversion_active),
  .over_limit_out(over_limit_out), .under_limit_out(under_limit_out),
  .hysteresis_out(hysteresis_out));

// ---- dv/ttc_host_model.sv ----
// Purpose: Controller on the far side of the three-wire port.
// Assumes: Serial clock period of 9 sys_clk cycles (4 low, 5 high), idle high between frames.
// Notes: An undriven data line shows the inverse of its last level.
`timescale 1ns/10ps
module ttc_host_model (
  input wire logic sys_clk,
  output logic transfer_select,
  output logic clock_or_convert_pin,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  logic drv = 1'b1;
  logic bit_q = 1'b0;
  logic last = 1'b0;
  initial transfer_select = 1'b0;
  initial clock_or_convert_pin = 1'b1;
  assign serial_data_in = drv ? bit_q : (serial_data_oe ? serial_data_out : ~last);
  always @(posedge sys_clk) last <= serial_data_in;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pin(input logic v);
    @(posedge sys_clk);
    clock_or_convert_pin <= v;
  endtask
  task automatic clk_cycle(input logic b, input logic wr, output logic [1:0] got);
    @(posedge sys_clk);
    clock_or_convert_pin <= 1'b0;
    drv <= wr;
    bit_q <= b;
    tick(4);
    got = {serial_data_oe, serial_data_in};
    clock_or_convert_pin <= 1'b1;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [8:0] wd, input int nw,
                      input int nr, output logic [15:0] rd, output logic oe_ok);
    logic [1:0] g;
    int i;
    rd = 16'h0000;
    oe_ok = 1'b1;
    @(posedge sys_clk);
    transfer_select <= 1'b1;
    tick(4);
    for (i = 0; i < 8; i++) clk_cycle(cmd[i], 1'b1, g);
    for (i = 0; i < nw; i++) clk_cycle(wd[i], 1'b1, g);
    for (i = 0; i < nr; i++) begin
      clk_cycle(1'b0, 1'b0, g);
      rd[i] = g[0];
      oe_ok = oe_ok & g[1];
    end
    @(posedge sys_clk);
    transfer_select <= 1'b0;
    drv <= 1'b1;
    tick(4);
  endtask
endmodule

// ---- dv/ttc_thermostat_tb_top.sv ----
// Purpose: Self-checking bench for the thermostat three-wire control block.
// Assumes: Short conversion and hold counts; limits 25 and -25 degrees.
// Notes: All serial traffic goes through the host model's tasks.
`timescale 1ns/10ps
module ttc_thermostat_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  ttc_pkg::ttc_temp_t sensor_temp = 9'h000;
  logic sel, pin, din, dout, doe, act, over, under, hyst, ok;
  logic [15:0] rd;
  int fail_count = 0;
  int num_checks = 0;
  always #4 sys_clk = ~sys_clk;
  ttc_thermostat #(.CONV_CYCLES(50), .HOLD_CYCLES(20)) uut (.sys_clk(sys_clk), .reset(reset),
    .transfer_select(sel), .clock_or_convert_pin(pin), .serial_data_in(din),
    .serial_data_out(dout), .serial_data_oe(doe), .sensor_temp(sensor_temp),
    .conversion_active(act), .over_limit_out(over), .under_limit_out(under),
    .hysteresis_out(hyst));
  ttc_host_model host (.sys_clk(sys_clk), .transfer_select(sel), .clock_or_convert_pin(pin),
    .serial_data_in(din), .serial_data_out(dout), .serial_data_oe(doe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_cmd(input logic [7:0] c, input int n, input logic [15:0] exp);
    host.xfer(c, 9'h000, 0, n, rd, ok);
    chk(rd, exp);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic wr_cmd(input logic [7:0] c, input logic [8:0] d, input int n);
    host.xfer(c, d, n, 0, rd, ok);
  endtask
  task automatic wait_act(input int n, input logic e);
    repeat (n) @(posedge sys_clk);
    chk({15'h0000, act}, {15'h0000, e});
  endtask
  task automatic outs(input logic [2:0] e);
    chk({13'h0000, over, under, hyst}, {13'h0000, e});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_cmd(8'hAC, 8, 16'h0082);
    host.pin(1'b0);
    repeat (8) @(posedge sys_clk);
    host.pin(1'b1);
    wait_act(8, 1'b0);
    wr_cmd(8'h01, 9'h032, 9);
    wr_cmd(8'h02, 9'h1CE, 9);
    rd_cmd(8'hA1, 12, 16'h0032);
    rd_cmd(8'hA2, 9, 16'h01CE);
    wr_cmd(8'h0C, 9'h003, 8);
    sensor_temp <= 9'h043;
    wr_cmd(8'hEE, 9'h000, 0);
    rd_cmd(8'hAC, 8, 16'h00C3);
    wait_act(60, 1'b0);
    outs(3'b101);
    rd_cmd(8'hAC, 8, 16'h00C3);
    rd_cmd(8'hAA, 16, 16'h0043);
    sensor_temp <= 9'h005;
    wait_act(100, 1'b0);
    outs(3'b101);
    wr_cmd(8'hEE, 9'h000, 0);
    wait_act(60, 1'b0);
    outs(3'b001);
    sensor_temp <= 9'h1BA;
    wr_cmd(8'hEE, 9'h000, 0);
    wait_act(60, 1'b0);
    outs(3'b010);
    rd_cmd(8'hAC, 8, 16'h00E3);
    wr_cmd(8'h0C, 9'h003, 8);
    rd_cmd(8'hAC, 8, 16'h0083);
    wr_cmd(8'h0C, 9'h002, 8);
    wr_cmd(8'hEE, 9'h000, 0);
    wait_act(120, 1'b1);
    rd_cmd(8'hAC, 8, 16'h0022);
    wr_cmd(8'h22, 9'h000, 0);
    wait_act(60, 1'b0);
    wait_act(100, 1'b0);
    wr_cmd(8'h0C, 9'h001, 8);
    host.pin(1'b0);
    repeat (8) @(posedge sys_clk);
    host.pin(1'b1);
    wait_act(4, 1'b1);
    wait_act(150, 1'b0);
    host.pin(1'b0);
    wait_act(130, 1'b1);
    host.pin(1'b1);
    wait_act(150, 1'b0);
    final_report();
  end
endmodule
